// *** hdl/icr_bank.sv ***
// Indexed configuration register bank: index port and data port.
// Assumes host strobes are one-cycle pulses on clk_sys_in.
// power_on_in clears to defaults; reset_in keeps register values but exits config mode.
//
// Behaviour
// RULE1: Index-port write in config mode loads index
// RULE2: Data port accesses selected register 00..1F
// RULE3: Index reachable only in configuration mode
// RULE4: Power-up defaults; ordinary reset keeps values
// RULE5: Register zero via index 00, 28H
// RULE6: Register zero bits 0,1 read zero
// RULE7: Bit 2 repurposes second select/motor pins
// RULE8: Bit 3 powers core, clear means low-power
// RULE9: Register zero bits 4,6 read zero
// RULE10: Bit 5 switches oscillator, default on
// RULE11: Bit 7 plain software flag, cleared
// RULE12: Two back-to-back 55H writes enter config
// RULE13: Intervening other write cancels unlock
// RULE14: AAH at index port exits config
// RULE15: Outside config mode, accesses change nothing
module icr_bank #(
  parameter logic [7:0] PART_ID = icr_pkg::DEF_PART_ID,
  parameter logic [7:0] PART_REV = icr_pkg::DEF_PART_REV
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic power_on_in,
  input wire icr_pkg::icr_host_t host_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic config_mode_out,
  input wire logic drive_select_1_in,
  input wire logic motor_on_1_in,
  input wire logic powerdown_state_in,
  input wire logic idle_state_in,
  output logic second_drive_select_out,
  output logic second_motor_on_out,
  output icr_pkg::icr_ctrl_t ctrl_out
);

  // ----------------------------------------------------------------
  // Unlock sequencer
  // ----------------------------------------------------------------
  logic config_mode;
  logic unlock_reset;

  // Either reset drops back to normal mode
  assign unlock_reset = reset_in || power_on_in;

  icr_unlock u_unlock (
    .clk_sys_in(clk_sys_in),
    .reset_in(unlock_reset),
    .wr_in(host_in.wr),
    .port_in(host_in.port),
    .data_in(host_in.data),
    .config_mode_out(config_mode)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [icr_pkg::IDX_W-1:0] index_reg;
  logic index_valid_reg;
  logic wr_index;
  logic wr_data;
  logic rd_data;
  logic lock_open;
  logic [7:0] wdata;

  assign wdata = host_in.data;
  // Exit key is a write to the index port too; loading it is harmless
  assign wr_index = host_in.wr && config_mode
                    && host_in.port == icr_pkg::PORT_INDEX; // RULE3 RULE15
  // Data port is dead until the index has been set in this session
  assign wr_data = host_in.wr && config_mode && index_valid_reg
                   && lock_open
                   && host_in.port == icr_pkg::PORT_DATA; // RULE3 RULE15
  assign rd_data = host_in.rd && config_mode && index_valid_reg
                   && lock_open
                   && host_in.port == icr_pkg::PORT_DATA; // RULE2

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || power_on_in || !config_mode) begin
      index_reg <= '0;
      index_valid_reg <= 1'b0;
    end else if (wr_index) begin
      index_reg <= wdata[icr_pkg::IDX_W-1:0]; // RULE1
      index_valid_reg <= 1'b1; // RULE3
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // Only power_on_in restores defaults; reset_in is deliberately absent
  logic [7:0] regs_reg [icr_pkg::NUM_REGS];
  logic [7:0] rst_val [icr_pkg::NUM_REGS];
  logic [7:0] wr_mask [icr_pkg::NUM_REGS];

  genvar gi;
  generate
    for (gi = 0; gi < icr_pkg::NUM_REGS; gi++) begin : g_reg
      localparam logic [4:0] IDX = 5'(gi);
      assign rst_val[gi] =
        (IDX == icr_pkg::IDX_POWER_CLOCK) ? icr_pkg::RST_POWER_CLOCK :
        (IDX == icr_pkg::IDX_CONFIG_LOCK) ? icr_pkg::RST_CONFIG_LOCK :
        (IDX == icr_pkg::IDX_IFACE_MODE) ? icr_pkg::RST_IFACE_MODE :
        (IDX == icr_pkg::IDX_DRIVE_TYPE_MAP) ?
          icr_pkg::RST_DRIVE_TYPE_MAP :
        icr_pkg::ZERO_BYTE; // RULE4 RULE5 RULE11
      assign wr_mask[gi] =
        (IDX == icr_pkg::IDX_POWER_CLOCK) ? icr_pkg::MASK_POWER_CLOCK :
        (IDX == icr_pkg::IDX_CONFIG_LOCK) ? icr_pkg::MASK_CONFIG_LOCK :
        (IDX == icr_pkg::IDX_IFACE_MODE) ? icr_pkg::MASK_IFACE_MODE :
        (IDX == icr_pkg::IDX_DMA_DENSITY) ? icr_pkg::MASK_DMA_DENSITY :
        (IDX == icr_pkg::IDX_DRIVE_TYPE_MAP
         || IDX == icr_pkg::IDX_BOOT_DRIVE
         || IDX == icr_pkg::IDX_DRIVE_RATE
         || IDX == icr_pkg::IDX_TEST_ZERO
         || IDX == icr_pkg::IDX_TEST_ONE
         || IDX == icr_pkg::IDX_TEST_TWO
         || IDX == icr_pkg::IDX_DRIVE_TYPE_TABLE) ? icr_pkg::MASK_ALL :
        icr_pkg::ZERO_BYTE; // RULE6 RULE9

      logic hit;
      assign hit = wr_data && index_reg == IDX; // RULE2
      always_ff @(posedge clk_sys_in) begin
        if (power_on_in) begin
          regs_reg[gi] <= rst_val[gi]; // RULE4
        end else if (hit) begin
          regs_reg[gi] <= (regs_reg[gi] & ~wr_mask[gi])
                          | (wdata & wr_mask[gi]);
        end
      end
    end
  endgenerate

  // Lock bit: once cleared, only power-up reopens the bank
  logic lock_reg;
  always_ff @(posedge clk_sys_in) begin
    if (power_on_in) begin
      lock_reg <= 1'b1;
    end else if (wr_data && index_reg == icr_pkg::IDX_CONFIG_LOCK
                 && !wdata[icr_pkg::BIT_LOCK]) begin
      lock_reg <= 1'b0;
    end
  end
  assign lock_open = lock_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] lock_view;
  logic [7:0] rd_mux;

  always_comb begin
    lock_view = regs_reg[icr_pkg::IDX_CONFIG_LOCK];
    lock_view[icr_pkg::BIT_LOCK] = lock_reg;
  end

  assign rd_mux =
    (index_reg == icr_pkg::IDX_PART_ID) ? PART_ID :
    (index_reg == icr_pkg::IDX_PART_REV) ? PART_REV :
    (index_reg == icr_pkg::IDX_CONFIG_LOCK) ? lock_view :
    regs_reg[index_reg]; // RULE2

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || power_on_in) begin
      rd_data_out <= icr_pkg::ZERO_BYTE;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_data;
      if (rd_data) begin
        rd_data_out <= rd_mux; // RULE2
      end
    end
  end

  assign config_mode_out = config_mode;

  // ----------------------------------------------------------------
  // Controls to the core
  // ----------------------------------------------------------------
  logic [7:0] pwr;
  assign pwr = regs_reg[icr_pkg::IDX_POWER_CLOCK];

  // Pin function swap is purely combinational so it tracks the core
  assign second_drive_select_out = pwr[icr_pkg::BIT_PIN_SWAP] ?
    powerdown_state_in : drive_select_1_in; // RULE7
  assign second_motor_on_out = pwr[icr_pkg::BIT_PIN_SWAP] ?
    idle_state_in : motor_on_1_in; // RULE7

  always_comb begin
    ctrl_out.powerdown_pin_enable = pwr[icr_pkg::BIT_PIN_SWAP]; // RULE7
    ctrl_out.core_power_enable = pwr[icr_pkg::BIT_CORE_POWER]; // RULE8
    ctrl_out.oscillator_control = pwr[icr_pkg::BIT_OSCILLATOR]; // RULE10
    ctrl_out.drive_type_map = regs_reg[icr_pkg::IDX_DRIVE_TYPE_MAP];
    ctrl_out.boot_drive_power_mgmt = regs_reg[icr_pkg::IDX_BOOT_DRIVE];
    ctrl_out.drive_rate_table = regs_reg[icr_pkg::IDX_DRIVE_RATE];
    ctrl_out.drive_type_table = regs_reg[icr_pkg::IDX_DRIVE_TYPE_TABLE];
    ctrl_out.dma_density_select = regs_reg[icr_pkg::IDX_DMA_DENSITY];
    ctrl_out.interface_mode = regs_reg[icr_pkg::IDX_IFACE_MODE];
  end
  // Bit 7 of register zero drives nothing: software flag only  RULE11

endmodule // icr_bank

// *** hdl/icr_pkg.sv ***
// Package for the indexed configuration register bank.
// Assumes a single host-bus clock domain and synchronous reset.
package icr_pkg;

  // ----------------------------------------------------------------
  // Ports, keys and sizes
  // ----------------------------------------------------------------
  localparam logic [0:0] PORT_INDEX = 1'h0;
  localparam logic [0:0] PORT_DATA = 1'h1;
  localparam logic [7:0] KEY_ENTER = 8'h55;
  localparam logic [7:0] KEY_EXIT = 8'haa;
  localparam int NUM_REGS = 32;
  localparam int IDX_W = 5;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_POWER_CLOCK = 5'h00;
  localparam logic [4:0] IDX_CONFIG_LOCK = 5'h01;
  localparam logic [4:0] IDX_IFACE_MODE = 5'h03;
  localparam logic [4:0] IDX_DMA_DENSITY = 5'h05;
  localparam logic [4:0] IDX_DRIVE_TYPE_MAP = 5'h06;
  localparam logic [4:0] IDX_BOOT_DRIVE = 5'h07;
  localparam logic [4:0] IDX_DRIVE_RATE = 5'h0b;
  localparam logic [4:0] IDX_PART_ID = 5'h0d;
  localparam logic [4:0] IDX_PART_REV = 5'h0e;
  localparam logic [4:0] IDX_TEST_ZERO = 5'h0f;
  localparam logic [4:0] IDX_TEST_ONE = 5'h10;
  localparam logic [4:0] IDX_TEST_TWO = 5'h11;
  localparam logic [4:0] IDX_DRIVE_TYPE_TABLE = 5'h1f;

  // ----------------------------------------------------------------
  // Power-up values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_POWER_CLOCK = 8'h28;
  localparam logic [7:0] MASK_POWER_CLOCK = 8'hac;
  localparam logic [7:0] RST_CONFIG_LOCK = 8'h90;
  localparam logic [7:0] MASK_CONFIG_LOCK = 8'h80;
  localparam logic [7:0] RST_IFACE_MODE = 8'h70;
  localparam logic [7:0] MASK_IFACE_MODE = 8'h72;
  localparam logic [7:0] RST_DRIVE_TYPE_MAP = 8'hff;
  localparam logic [7:0] MASK_DMA_DENSITY = 8'hfc;
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Power/clock and config-lock register bit positions
  localparam int BIT_PIN_SWAP = 2;
  localparam int BIT_CORE_POWER = 3;
  localparam int BIT_OSCILLATOR = 5;
  localparam int BIT_VALID = 7;
  localparam int BIT_LOCK = 7;

  // Arbitrary identity values
  localparam logic [7:0] DEF_PART_ID = 8'h5a;
  localparam logic [7:0] DEF_PART_REV = 8'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic port;
    logic [7:0] data;
  } icr_host_t;

  typedef struct packed {
    logic powerdown_pin_enable;
    logic core_power_enable;
    logic oscillator_control;
    logic [7:0] drive_type_map;
    logic [7:0] boot_drive_power_mgmt;
    logic [7:0] drive_rate_table;
    logic [7:0] drive_type_table;
    logic [7:0] dma_density_select;
    logic [7:0] interface_mode;
  } icr_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_CONFIG = 3'b100
  } icr_state_t;

endpackage // icr_pkg

// *** hdl/icr_unlock.sv ***
// Configuration-mode unlock sequencer.
// Assumes one write strobe per host write, same clock domain.
module icr_unlock (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic wr_in,
  input wire logic port_in,
  input wire logic [7:0] data_in,
  output logic config_mode_out
);

  icr_pkg::icr_state_t state_reg;
  icr_pkg::icr_state_t state_next;
  logic key_enter;
  logic key_exit;
  logic at_index;

  assign at_index = port_in == icr_pkg::PORT_INDEX;
  assign key_enter = wr_in && at_index && data_in == icr_pkg::KEY_ENTER;
  assign key_exit = wr_in && at_index && data_in == icr_pkg::KEY_EXIT;

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      icr_pkg::ST_IDLE: begin
        if (key_enter) begin
          state_next = icr_pkg::ST_ARMED; // RULE12
        end
      end
      icr_pkg::ST_ARMED: begin
        // Any other write breaks the pair
        if (key_enter) begin
          state_next = icr_pkg::ST_CONFIG; // RULE12
        end else if (wr_in) begin
          state_next = icr_pkg::ST_IDLE; // RULE13
        end
      end
      icr_pkg::ST_CONFIG: begin
        if (key_exit) begin
          state_next = icr_pkg::ST_IDLE; // RULE14
        end
      end
      default: state_next = icr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_reg <= icr_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign config_mode_out = state_reg == icr_pkg::ST_CONFIG;

endmodule // icr_unlock

// *** tb/icr_bank_assertions.sv ***
// Port-level checker for the configuration register bank.
// Assumes one clock domain, bound onto icr_bank from the bench.
module icr_bank_assertions (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic power_on_in,
  input wire icr_pkg::icr_host_t host_in,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic config_mode_out,
  input wire logic drive_select_1_in,
  input wire logic motor_on_1_in,
  input wire logic powerdown_state_in,
  input wire logic idle_state_in,
  input wire logic second_drive_select_out,
  input wire logic second_motor_on_out,
  input wire icr_pkg::icr_ctrl_t ctrl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in || power_on_in);
  wire logic base_wr = host_in.wr && !host_in.port;
  wire logic key_on = base_wr && host_in.data == icr_pkg::KEY_ENTER;
  wire logic key_off = base_wr && host_in.data == icr_pkg::KEY_EXIT;
  wire logic pin_swap = ctrl_out.powerdown_pin_enable;
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  chk_enter_mode: assert property (
    (!config_mode_out && key_on) ##1 key_on |=> config_mode_out)
    else $error("config mode not entered");
  chk_exit_mode: assert property (
    config_mode_out && key_off |=> !config_mode_out)
    else $error("config mode not left");
  chk_rd_origin: assert property (
    rd_valid_out |-> $past(host_in.rd) && $past(host_in.port)
      && $past(config_mode_out))
    else $error("read answered without config access");
  chk_base_rd: assert property (
    host_in.rd && !host_in.port |=> !rd_valid_out)
    else $error("base port read answered");
  // Ordinary reset clears the read latch as well
  chk_rd_hold: assert property (
    $changed(rd_data_out) |-> rd_valid_out
      || ($past(reset_in) && rd_data_out == icr_pkg::ZERO_BYTE))
    else $error("read data moved without a read");
  chk_swap_select: assert property (
    second_drive_select_out ==
      (pin_swap ? powerdown_state_in : drive_select_1_in))
    else $error("second select pin wrong");
  chk_swap_motor: assert property (
    second_motor_on_out == (pin_swap ? idle_state_in : motor_on_1_in))
    else $error("second motor pin wrong");
  chk_ctrl_frozen: assert property (
    !config_mode_out |=> $stable(ctrl_out))
    else $error("controls changed outside config mode");
  chk_reset_keeps: assert property (
    @(posedge clk_sys_in) disable iff (power_on_in)
    reset_in |=> $stable(ctrl_out) && !config_mode_out)
    else $error("ordinary reset disturbed the bank");
endmodule // icr_bank_assertions

// *** tb/icr_bank_tb.sv ***
// Self-checking bench for the configuration register bank.
// Assumes host strobes may be driven on falling edges.
module icr_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 0;
  logic reset_in = 1;
  logic power_on_in = 1;
  logic ds1 = 0, mt1 = 0, pd = 0, idl = 0;
  icr_pkg::icr_host_t host = '0;
  logic [7:0] rdd;
  logic rdv, cfg, sds, smo;
  icr_pkg::icr_ctrl_t ctrl;
  int n_mismatch = 0;
  int total_checks = 0;

  icr_bank u_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .power_on_in(power_on_in), .host_in(host), .rd_data_out(rdd),
    .rd_valid_out(rdv), .config_mode_out(cfg),
    .drive_select_1_in(ds1), .motor_on_1_in(mt1),
    .powerdown_state_in(pd), .idle_state_in(idl),
    .second_drive_select_out(sds), .second_motor_on_out(smo),
    .ctrl_out(ctrl));

  initial begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Whole struct each call, so strobes last one cycle
  task automatic op(input logic w, r, p, input logic [7:0] d);
    @(negedge clk_sys_in);
    host = '{wr: w, rd: r, port: p, data: d};
  endtask
  task automatic rd(input logic [7:0] e);
    op(0, 1, 1, 8'h00);
    op(0, 0, 0, 8'h00);
    chk(rdv, 1);
    chk(rdd, e);
  endtask
  task automatic nord(input logic p);
    op(0, 1, p, 8'h00);
    op(0, 0, 0, 8'h00);
    chk(rdv, 0);
  endtask
  task automatic enter;
    op(1, 0, 0, 8'h55);
    op(1, 0, 0, 8'h55);
    op(0, 0, 0, 8'h00);
    chk(cfg, 1);
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_defaults;
    logic [4:0] ix [7] = '{5'h00, 5'h01, 5'h03, 5'h06, 5'h0d, 5'h0e,
      5'h02};
    logic [7:0] ev [7] = '{8'h28, 8'h90, 8'h70, 8'hff,
      icr_pkg::DEF_PART_ID, icr_pkg::DEF_PART_REV, 8'h00};
    enter();
    chk(ctrl.core_power_enable, 1);
    chk(ctrl.oscillator_control, 1);
    chk(ctrl.interface_mode, 8'h70);
    for (int i = 0; i < 7; i++) begin
      op(1, 0, 0, {3'h0, ix[i]});
      rd(ev[i]);
    end
    $display("test defaults done");
  endtask
  task automatic t_reg0;
    op(1, 0, 0, 8'h00);
    op(1, 0, 1, 8'h3f);
    rd(8'h2c);
    op(1, 0, 1, 8'hff);
    rd(8'hac);
    op(1, 0, 1, 8'h00);
    rd(8'h00);
    chk(ctrl.core_power_enable, 0);
    chk(ctrl.oscillator_control, 0);
    for (int j = 0; j < 2; j++) begin
      op(1, 0, 1, j ? 8'h04 : 8'h00);
      op(0, 0, 0, 8'h00);
      for (int k = 0; k < 16; k++) begin
        @(negedge clk_sys_in);
        {pd, idl, ds1, mt1} = k[3:0];
        #1;
        chk(sds, j ? pd : ds1);
        chk(smo, j ? idl : mt1);
      end
    end
    op(1, 0, 1, 8'h84);
    rd(8'h84);
    $display("test register zero done");
  endtask
  // Same byte everywhere, so the masks show in what comes back
  task automatic t_bytes;
    logic [4:0] ix [8] = '{5'h03, 5'h05, 5'h06, 5'h07, 5'h0b, 5'h0f,
      5'h1f, 5'h02};
    logic [7:0] ev [8] = '{8'h52, 8'h58, 8'h5a, 8'h5a, 8'h5a, 8'h5a,
      8'h5a, 8'h00};
    for (int i = 0; i < 8; i++) begin
      op(1, 0, 0, {3'h0, ix[i]});
      op(1, 0, 1, 8'h5a);
      rd(ev[i]);
    end
    chk(ctrl.interface_mode, 8'h52);
    chk(ctrl.dma_density_select, 8'h58);
    chk(ctrl.drive_type_map, 8'h5a);
    chk(ctrl.boot_drive_power_mgmt, 8'h5a);
    chk(ctrl.drive_rate_table, 8'h5a);
    chk(ctrl.drive_type_table, 8'h5a);
    $display("test byte registers done");
  endtask
  task automatic t_reset;
    @(negedge clk_sys_in);
    reset_in = 1;
    @(negedge clk_sys_in);
    reset_in = 0;
    chk(cfg, 0);
    chk(ctrl.powerdown_pin_enable, 1);
    chk(ctrl.interface_mode, 8'h52);
    chk(ctrl.drive_type_map, 8'h5a);
    enter();
    nord(1);
    op(1, 0, 0, 8'h00);
    rd(8'h84);
    $display("test reset done");
  endtask
  task automatic t_exit;
    op(1, 0, 0, 8'haa);
    op(0, 0, 0, 8'h00);
    chk(cfg, 0);
    nord(1);
    nord(0);
    op(1, 0, 1, 8'h00);
    op(0, 0, 0, 8'h00);
    chk(ctrl.powerdown_pin_enable, 1);
    op(1, 0, 0, 8'h55);
    op(1, 0, 1, 8'h12);
    op(1, 0, 0, 8'h55);
    op(0, 0, 0, 8'h00);
    chk(cfg, 0);
    enter();
    op(1, 0, 0, 8'h00);
    rd(8'h84);
    // Clearing the lock shuts the data port until power-up
    op(1, 0, 0, 8'h01);
    op(1, 0, 1, 8'h00);
    nord(1);
    $display("test exit done");
  endtask

  initial begin
    repeat (6) @(negedge clk_sys_in);
    power_on_in = 0;
    reset_in = 0;
    t_defaults();
    t_reg0();
    t_bytes();
    t_reset();
    t_exit();
    results();
  end
  // Whole run is well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    results();
  end
endmodule // icr_bank_tb

bind icr_bank icr_bank_assertions u_chk (.clk_sys_in(clk_sys_in),
  .reset_in(reset_in), .power_on_in(power_on_in), .host_in(host_in),
  .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
  .config_mode_out(config_mode_out),
  .drive_select_1_in(drive_select_1_in), .motor_on_1_in(motor_on_1_in),
  .powerdown_state_in(powerdown_state_in), .idle_state_in(idle_state_in),
  .second_drive_select_out(second_drive_select_out),
  .second_motor_on_out(second_motor_on_out), .ctrl_out(ctrl_out));
